/* File: core/sis_map.svh */
`ifndef SIS_MAP_SVH
`define SIS_MAP_SVH
// Operation
// - Hold CKE high, NOPs only, first idle
// - Issue reset mode write after first idle
// - Optional precharge all before reset
// - NOPs with CKE high after reset
// - Only mode reads until initialization completes
// - CKE low only by power-down rules
// - Proceed on auto-init timeout or done flag
// - Relaxed timing until configuration completes
// - Boot mode reads need 18-100 ns clock
// - Calibration write after auto-init phase
// - Never overlap calibration across devices
// - Wait calibration time before normal use
// - Write mode registers one, two, three
// - Any reset restarts from reset point
// - CKE low during power-off, outputs float
// - Reserved mode bits written as zero

// Clock and boot clock window, in ns
`define SIS_CLK_PERIOD_NS 25
`define SIS_BOOT_TCK_MIN_NS 18
`define SIS_BOOT_TCK_MAX_NS 100
// Waits in their printed units
`define SIS_INIT_IDLE_US 200
`define SIS_POST_RST_US 1
`define SIS_AUTO_INIT_MAX_US 10
`define SIS_ZQ_INIT_US 1
// Least times round up, longest times round down
`define SIS_CEIL_CYC(ns) (((ns) + `SIS_CLK_PERIOD_NS - 1) / `SIS_CLK_PERIOD_NS)
`define SIS_FLOOR_CYC(ns) ((ns) / `SIS_CLK_PERIOD_NS)
`define SIS_INIT_IDLE_CYC `SIS_CEIL_CYC(`SIS_INIT_IDLE_US * 1000)
`define SIS_POST_RST_CYC `SIS_CEIL_CYC(`SIS_POST_RST_US * 1000)
`define SIS_AUTO_INIT_CYC `SIS_FLOOR_CYC(`SIS_AUTO_INIT_MAX_US * 1000)
`define SIS_ZQ_INIT_CYC `SIS_CEIL_CYC(`SIS_ZQ_INIT_US * 1000)
// Mode register addresses and values
`define SIS_MA_INFO 8'h00
`define SIS_MA_FEAT1 8'h01
`define SIS_MA_FEAT2 8'h02
`define SIS_MA_IOCFG 8'h03
`define SIS_MA_CAL 8'h0a
`define SIS_MA_RESET 8'h3f
`define SIS_OP_RESET 8'h00
`define SIS_RFU_MASK_LO 8'h0f
`define SIS_DAI_BIT 0
// Own register offsets
`define SIS_OFF_CTRL 8'h00
`define SIS_OFF_MR1 8'h04
`define SIS_OFF_MR2 8'h08
`define SIS_OFF_MR3 8'h0c
`define SIS_OFF_CAL 8'h10
`define SIS_OFF_STATUS 8'h14
// Control bits
`define SIS_CTRL_START 0
`define SIS_CTRL_PREA_EN 1
`define SIS_CTRL_POWER_OFF 2
`define SIS_CTRL_REINIT 3
// Status bits
`define SIS_ST_READY 4
`define SIS_ST_TIMEOUT 5
`define SIS_ST_BOOT 6
`define SIS_ST_DAI_OK 7
// Reset values
`define SIS_RST_MR 8'h00
`define SIS_RST_PREA_EN 1'b0
`endif

/* File: core/sis_pkg.sv */
package sis_pkg;
	// Command kinds on the command/address bus
	typedef enum logic [1:0] {SIS_NOP, SIS_PREA, SIS_MRW, SIS_MRR} sis_kind_t;
	// One command slot
	typedef struct packed {
		sis_kind_t kind;
		logic [7:0] ma;
		logic [7:0] op;
	} sis_cmd_t;
	// Mode read answer
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sis_mrr_t;
	// Sequencer states
	typedef enum logic [3:0] {
		S_OFF, S_IDLE_WAIT, S_PREA, S_RESET, S_POST_RST, S_POLL_ISSUE, S_POLL_WAIT,
		S_ZQ, S_ZQ_WAIT, S_MR1, S_MR2, S_MR3, S_READY
	} sis_state_t;
endpackage

/* File: core/sis_timer.sv */
`timescale 1ns/100ps
// Down counter: loads a count, then runs to zero and rests there
module sis_timer #(
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	output logic expired
);
	logic [CNT_W-1:0] cnt_q; // Remaining cycles

	if (CNT_W < 2) begin : g_bad_width
		$error("sis_timer: CNT_W must be at least 2");
	end

	// Zero means the wait is over; a fresh load of a nonzero count clears it
	assign expired = (cnt_q == '0);

	////////////////////////////////////////////////////////////////////////
	// Count down, one cycle per edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // sis_timer

/* File: core/sis_ctrl.sv */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "sis_map.svh"
// Boot sequencer for a low-power SDRAM with an APB register port
module sis_ctrl import sis_pkg::*; #(
	parameter int CNT_W = 16,
	parameter int INIT_IDLE_CYC = `SIS_INIT_IDLE_CYC,
	parameter int CLK_PERIOD_NS = `SIS_CLK_PERIOD_NS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	output sis_cmd_t cmd_q,
	output logic cke_q,
	input wire sis_mrr_t mrr,
	output logic boot_timing_q,
	output logic ready_q
);
	localparam int POST_CYC = `SIS_POST_RST_CYC;
	localparam int AI_CYC = `SIS_AUTO_INIT_CYC;
	localparam int ZQ_CYC = `SIS_ZQ_INIT_CYC;

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	// Mode reads are issued at this clock, so it must sit in the boot window
	if (CLK_PERIOD_NS < `SIS_BOOT_TCK_MIN_NS || CLK_PERIOD_NS > `SIS_BOOT_TCK_MAX_NS) begin : g_bad_clk
		$error("sis_ctrl: clock period outside boot window");
	end
	if (INIT_IDLE_CYC < 1 || INIT_IDLE_CYC >= (2 ** CNT_W)) begin : g_bad_idle
		$error("sis_ctrl: INIT_IDLE_CYC does not fit CNT_W");
	end
	if (AI_CYC >= (2 ** CNT_W) || AI_CYC <= POST_CYC) begin : g_bad_ai
		$error("sis_ctrl: auto-init wait does not fit CNT_W");
	end

	// Address decode for the error answer; the read mux compares addresses itself
	function automatic logic is_mapped(input logic [7:0] a);
		return a == `SIS_OFF_CTRL || a == `SIS_OFF_MR1 || a == `SIS_OFF_MR2 ||
			a == `SIS_OFF_MR3 || a == `SIS_OFF_CAL || a == `SIS_OFF_STATUS;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Declarations
	sis_state_t state_q, state_d; // Sequencer state
	logic prea_en_q; // Precharge all before reset
	logic [7:0] mr1_q, mr2_q, mr3_q, cal_q; // Configuration images
	logic timeout_q, timeout_d; // Auto-init ended by time, not by flag
	logic dai_ok_q, dai_ok_d; // Auto-init ended by the flag
	sis_cmd_t cmd_d; // Next command slot
	logic seq_load; // Load sequence timer
	logic [CNT_W-1:0] seq_val; // Sequence timer value
	logic seq_exp, ai_exp; // Timer expiries
	logic ai_load; // Auto-init timer start
	logic acc; // APB access completes this edge
	logic wr_ctrl; // Control write
	logic go_start, go_off, go_reinit; // Control pulses
	logic [31:0] rd_mux; // Read data
	logic [31:0] status_w; // Status word
	logic dai_clear; // Mode read shows auto-init done

	////////////////////////////////////////////////////////////////////////
	// APB slave: one access cycle, flop-driven answer
	assign acc = psel && penable && pready_q;
	assign wr_ctrl = acc && pwrite && paddr == `SIS_OFF_CTRL;
	assign go_start = wr_ctrl && pwdata[`SIS_CTRL_START];
	assign go_off = wr_ctrl && pwdata[`SIS_CTRL_POWER_OFF];
	assign go_reinit = wr_ctrl && pwdata[`SIS_CTRL_REINIT];
	assign status_w = {24'h000000, dai_ok_q, boot_timing_q, timeout_q, ready_q, 4'(state_q)};
	assign rd_mux = (paddr == `SIS_OFF_CTRL) ? {30'h0, prea_en_q, 1'b0} :
		(paddr == `SIS_OFF_MR1) ? {24'h000000, mr1_q} :
		(paddr == `SIS_OFF_MR2) ? {24'h000000, mr2_q} :
		(paddr == `SIS_OFF_MR3) ? {24'h000000, mr3_q} :
		(paddr == `SIS_OFF_CAL) ? {24'h000000, cal_q} :
		(paddr == `SIS_OFF_STATUS) ? status_w : 32'h00000000;

	// Answer is prepared in the setup cycle and shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && !is_mapped(paddr);
			prdata_q <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Configuration registers; reserved bits are dropped on the way in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prea_en_q <= `SIS_RST_PREA_EN;
			mr1_q <= `SIS_RST_MR;
			mr2_q <= `SIS_RST_MR;
			mr3_q <= `SIS_RST_MR;
			cal_q <= `SIS_RST_MR;
		end else if (acc && pwrite) begin
			if (paddr == `SIS_OFF_CTRL) prea_en_q <= pwdata[`SIS_CTRL_PREA_EN];
			if (paddr == `SIS_OFF_MR1) mr1_q <= pwdata[7:0];
			if (paddr == `SIS_OFF_MR2) mr2_q <= pwdata[7:0] & `SIS_RFU_MASK_LO;
			if (paddr == `SIS_OFF_MR3) mr3_q <= pwdata[7:0] & `SIS_RFU_MASK_LO;
			if (paddr == `SIS_OFF_CAL) cal_q <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timers: one for the sequence waits, one for the auto-init limit
	sis_timer #(.CNT_W(CNT_W)) u_seq_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.load(seq_load),
		.load_val(seq_val),
		.expired(seq_exp)
	);
	sis_timer #(.CNT_W(CNT_W)) u_ai_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.load(ai_load),
		.load_val(CNT_W'(AI_CYC)),
		.expired(ai_exp)
	);

	// The auto-init limit runs from the reset command itself
	assign ai_load = (state_q == S_RESET);
	assign dai_clear = mrr.valid && !mrr.data[`SIS_DAI_BIT];

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state and command slot
	always_comb begin
		state_d = state_q;
		cmd_d = '{kind: SIS_NOP, ma: 8'h00, op: 8'h00};
		seq_load = 1'b0;
		seq_val = '0;
		timeout_d = timeout_q;
		dai_ok_d = dai_ok_q;
		unique case (state_q)
			S_OFF: begin
				if (go_start) begin
					state_d = S_IDLE_WAIT;
					seq_load = 1'b1;
					seq_val = CNT_W'(INIT_IDLE_CYC);
				end
			end
			S_IDLE_WAIT: begin
				// NOPs with CKE high until the first idle is over
				if (seq_exp) state_d = prea_en_q ? S_PREA : S_RESET;
			end
			S_PREA: begin
				cmd_d.kind = SIS_PREA;
				state_d = S_RESET;
			end
			S_RESET: begin
				cmd_d = '{kind: SIS_MRW, ma: `SIS_MA_RESET, op: `SIS_OP_RESET};
				timeout_d = 1'b0;
				dai_ok_d = 1'b0;
				seq_load = 1'b1;
				seq_val = CNT_W'(POST_CYC);
				state_d = S_POST_RST;
			end
			S_POST_RST: begin
				if (seq_exp) state_d = S_POLL_ISSUE;
			end
			S_POLL_ISSUE: begin
				// Only mode reads of the info register while auto-init runs
				if (ai_exp) begin
					timeout_d = 1'b1;
					state_d = S_ZQ;
				end else begin
					cmd_d = '{kind: SIS_MRR, ma: `SIS_MA_INFO, op: 8'h00};
					state_d = S_POLL_WAIT;
				end
			end
			S_POLL_WAIT: begin
				if (dai_clear) begin
					dai_ok_d = 1'b1;
					state_d = S_ZQ;
				end else if (mrr.valid) begin
					state_d = S_POLL_ISSUE; // Flag still set: ask again
				end else if (ai_exp) begin
					timeout_d = 1'b1;
					state_d = S_ZQ;
				end
			end
			S_ZQ: begin
				// One device per bus, so calibrations never overlap
				cmd_d = '{kind: SIS_MRW, ma: `SIS_MA_CAL, op: cal_q};
				seq_load = 1'b1;
				seq_val = CNT_W'(ZQ_CYC);
				state_d = S_ZQ_WAIT;
			end
			S_ZQ_WAIT: begin
				if (seq_exp) state_d = S_MR1;
			end
			S_MR1: begin
				cmd_d = '{kind: SIS_MRW, ma: `SIS_MA_FEAT1, op: mr1_q};
				state_d = S_MR2;
			end
			S_MR2: begin
				cmd_d = '{kind: SIS_MRW, ma: `SIS_MA_FEAT2, op: mr2_q};
				state_d = S_MR3;
			end
			S_MR3: begin
				cmd_d = '{kind: SIS_MRW, ma: `SIS_MA_IOCFG, op: mr3_q};
				state_d = S_READY;
			end
			S_READY: begin
				state_d = S_READY;
			end
		endcase
		// Restart from the reset point; power-off beats everything
		if (go_reinit && state_q != S_OFF) begin
			state_d = prea_en_q ? S_PREA : S_RESET;
			cmd_d.kind = SIS_NOP;
			seq_load = 1'b0;
		end
		if (go_off) begin
			state_d = S_OFF;
			cmd_d.kind = SIS_NOP;
			seq_load = 1'b0;
		end
	end

	// Sequencer flops; CKE follows the next state so it never lags a command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_OFF;
			cmd_q <= '{kind: SIS_NOP, ma: 8'h00, op: 8'h00};
			cke_q <= 1'b0;
			timeout_q <= 1'b0;
			dai_ok_q <= 1'b0;
			boot_timing_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			// CKE stays high in every state but off; power-down is never used here
			cke_q <= (state_d != S_OFF);
			timeout_q <= timeout_d;
			dai_ok_q <= dai_ok_d;
			boot_timing_q <= (state_d != S_OFF) && (state_d != S_READY);
			ready_q <= (state_d == S_READY);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checker helpers: cycles since the last reset and calibration command
	logic [CNT_W-1:0] rst_age_q, zq_age_q;
	logic is_rst_cmd, is_zq_cmd;
	assign is_rst_cmd = cmd_q.kind == SIS_MRW && cmd_q.ma == `SIS_MA_RESET;
	assign is_zq_cmd = cmd_q.kind == SIS_MRW && cmd_q.ma == `SIS_MA_CAL;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_age_q <= '1;
			zq_age_q <= '1;
		end else begin
			rst_age_q <= is_rst_cmd ? '0 : (rst_age_q == '1 ? rst_age_q : rst_age_q + 1'b1);
			zq_age_q <= is_zq_cmd ? '0 : (zq_age_q == '1 ? zq_age_q : zq_age_q + 1'b1);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_off_cke_low: assert property (state_q == S_OFF |-> !cke_q && cmd_q.kind == SIS_NOP)
		else $error("CKE or command active while off");
	a_idle_nop_only: assert property (state_q == S_IDLE_WAIT |-> cke_q && cmd_q.kind == SIS_NOP)
		else $error("Command during first idle");
	a_reset_op_zero: assert property (is_rst_cmd |-> cmd_q.op == `SIS_OP_RESET
		##1 (cke_q || state_q == S_OFF))
		else $error("Reset write carries nonzero data");
	a_post_reset_quiet: assert property ((cmd_q.kind inside {SIS_MRW, SIS_MRR}) && !is_rst_cmd
		|-> rst_age_q >= CNT_W'(POST_CYC) - 1'b1)
		else $error("Command before post-reset idle ended");
	a_poll_mrr_only: assert property (state_q == S_POLL_WAIT && !go_off && !go_reinit
		|-> cmd_q.kind == SIS_MRR || $past(state_q) == S_POLL_WAIT)
		else $error("Non-read command while polling");
	a_zq_after_init: assert property (is_zq_cmd |-> dai_ok_q || timeout_q)
		else $error("Calibration before auto-init ended");
	a_timeout_bound: assert property ($rose(timeout_q) |-> rst_age_q >= CNT_W'(AI_CYC) - 1'b1)
		else $error("Auto-init timeout declared too early");
	a_mr1_after_zq: assert property (cmd_q.kind == SIS_MRW && cmd_q.ma == `SIS_MA_FEAT1
		|-> zq_age_q >= CNT_W'(ZQ_CYC) ##1 cmd_q.ma == `SIS_MA_FEAT2 ##1 cmd_q.ma == `SIS_MA_IOCFG)
		else $error("Mode writes out of order or calibration cut short");
	a_mr_rfu_zero: assert property (cmd_q.kind == SIS_MRW && (cmd_q.ma == `SIS_MA_FEAT2 ||
		cmd_q.ma == `SIS_MA_IOCFG) |-> (cmd_q.op & ~`SIS_RFU_MASK_LO) == 8'h00)
		else $error("Reserved mode bits written as one");
	a_ready_relaxed: assert property ($rose(ready_q) |-> !boot_timing_q && $past(state_q) == S_MR3)
		else $error("Ready without finishing configuration");
	a_reinit_restart: assert property (go_reinit && !go_off && state_q != S_OFF
		|=> state_q inside {S_PREA, S_RESET})
		else $error("Reinit did not return to reset point");
	// CKE stands high in every state but off; power-down entry is never used
	a_cke_high_on: assert property (state_q != S_OFF |-> cke_q)
		else $error("CKE low outside the off state");
	// The APB answer stands for exactly one cycle
	a_apb_one_wait: assert property (pready_q |=> !pready_q)
		else $error("APB ready held longer than one cycle");
endmodule // sis_ctrl

/* File: verification/sis_dev_model.sv */
`timescale 1ns/100ps
// Behavioural memory device: mode registers, auto-init flag and mode-read answers
module sis_dev_model import sis_pkg::*; #(
	parameter int AUTO_CYC = 60
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire sis_cmd_t cmd,
	input wire logic cke,
	input wire logic mute,
	output sis_mrr_t mrr,
	output logic [7:0] mr1,
	output logic [7:0] mr2,
	output logic [7:0] mr3,
	output logic [7:0] mr10
);
	int busy_cnt; // Cycles left of auto-init
	logic auto_init_flag; // High while auto-init runs
	logic [1:0] pend; // Read answer pipeline
	logic [7:0] noise; // Floating bus stand-in
	////////////////////////////////////////////////////////////////
	// Command decode; a precharge-all is simply accepted
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 0;
			auto_init_flag <= 1'b1;
			pend <= 2'b00;
			noise <= 8'h00;
			{mr1, mr2, mr3, mr10} <= 32'h0;
		end else begin
			noise <= noise + 8'h5b;
			pend <= {pend[0], 1'b0};
			// Flag clears once auto-init is over
			if (busy_cnt > 0) begin
				busy_cnt <= busy_cnt - 1;
			end else begin
				auto_init_flag <= 1'b0;
			end
			// Writes reach registers only by mode write; commands are taken with CKE high, even during auto-init
			if (cke && cmd.kind == SIS_MRW) begin
				case (cmd.ma)
					8'h3f: begin
						auto_init_flag <= 1'b1;
						busy_cnt <= AUTO_CYC;
					end
					8'h01: mr1 <= cmd.op;
					8'h02: mr2 <= cmd.op;
					8'h03: mr3 <= cmd.op;
					8'h0a: mr10 <= cmd.op;
					default: ;
				endcase
			end
			// Register zero reads; mute makes the device fail to answer
			if (cke && cmd.kind == SIS_MRR && cmd.ma == 8'h00 && !mute) begin
				pend[0] <= 1'b1;
			end
		end
	end
	// Outputs float while clock enable is low, so data is never steady then
	// One assignment of the whole struct keeps a single driver on the port
	assign mrr = '{valid: pend[1] && cke,
		data: (pend[1] && cke) ? {7'h00, auto_init_flag} : noise};
endmodule // sis_dev_model

/* File: verification/sis_ctrl_test.sv */
`timescale 1ns/100ps
// Bench: APB orders in, the command stream is timed and checked
module sis_ctrl_test import sis_pkg::*;;
	localparam int IDLE = 20; // Shortened first idle
	localparam int POST = 40; // Idle after reset, cycles
	localparam int AUTOMAX = 400; // Longest auto-init, cycles
	localparam int ZQ = 40; // Calibration time, cycles
	localparam int AUTO = 60; // Model auto-init length
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mute = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_q;
	logic pready_q, pslverr_q, cke_q, boot_timing_q, ready_q;
	logic [7:0] mr1, mr2, mr3, mr10;
	sis_cmd_t cmd_q;
	sis_mrr_t mrr;
	int cyc = 0, n_errors = 0, check_count = 0;
	sis_cmd_t cq[$]; // Commands seen
	int tq[$]; // Their cycle stamps
	sis_ctrl #(.INIT_IDLE_CYC(IDLE)) u_sis_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .cmd_q(cmd_q), .cke_q(cke_q), .mrr(mrr),
		.boot_timing_q(boot_timing_q), .ready_q(ready_q));
	sis_dev_model #(.AUTO_CYC(AUTO)) u_sis_dev_model (.pclk(pclk), .presetn(presetn), .cmd(cmd_q),
		.cke(cke_q), .mute(mute), .mrr(mrr), .mr1(mr1), .mr2(mr2), .mr3(mr3), .mr10(mr10));
	initial forever #12.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	// Record every non-NOP command; clock enable must hold, and relaxed timing while ready is low
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (presetn && cmd_q.kind !== SIS_NOP) begin
			cq.push_back(cmd_q);
			tq.push_back(cyc);
			chk("cke at command", 1, cke_q);
			if (!ready_q) chk("relaxed timing", 1, boot_timing_q);
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cmd(input string what, input sis_cmd_t exp, input sis_cmd_t got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; an idle edge first keeps strobes from being set twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_q !== 1'b1 && n < 16);
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			chk("apb answer", 1, 0);
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask
	// Next command from the record, optionally passing over poll reads
	task automatic next_cmd(input logic skip_mrr, output sis_cmd_t c, output int t);
		int n;
		n = 0;
		forever begin
			while (cq.size() == 0 && n < 2000) begin
				@(posedge pclk);
				n++;
			end
			if (cq.size() == 0) begin
				chk("command wait", 1, 0);
				finish_test();
			end
			c = cq.pop_front();
			t = tq.pop_front();
			if (!(skip_mrr && c.kind == SIS_MRR)) break;
		end
	endtask
	// Whole boot from the precharge or reset command to ready; first idle timed only without precharge, post-reset idle only unmuted
	task automatic expect_boot(input logic prea, input int t0, input logic mute_on);
		sis_cmd_t c;
		int t, trst, tz, n;
		logic [31:0] st;
		logic e;
		if (prea) begin
			next_cmd(1'b0, c, t);
			chk_cmd("precharge", '{SIS_PREA, c.ma, c.op}, c);
		end
		next_cmd(1'b0, c, t);
		chk_cmd("reset write", '{SIS_MRW, 8'h3f, 8'h00}, c);
		if (!prea) chk("first idle", 1, t - t0 > IDLE);
		trst = t;
		if (!mute_on) begin
			next_cmd(1'b0, c, t);
			chk_cmd("first poll", '{SIS_MRR, 8'h00, 8'h00}, c);
			chk("post reset idle", 1, t - trst > POST);
		end
		next_cmd(1'b1, c, t);
		chk_cmd("calibration", '{SIS_MRW, 8'h0a, 8'h5a}, c);
		chk("auto init wait", 1, mute_on ? t - trst >= AUTOMAX : t - trst > AUTO);
		tz = t;
		next_cmd(1'b0, c, t);
		chk_cmd("mode 1 write", '{SIS_MRW, 8'h01, 8'ha5}, c);
		chk("calibration wait", 1, t - tz > ZQ);
		next_cmd(1'b0, c, t);
		chk_cmd("mode 2 write", '{SIS_MRW, 8'h02, 8'h0f}, c);
		next_cmd(1'b0, c, t);
		chk_cmd("mode 3 write", '{SIS_MRW, 8'h03, 8'h0c}, c);
		n = 0;
		do begin
			apb(1'b0, 8'h14, 32'h0, st, e);
			n++;
		end while (st[4] !== 1'b1 && n < 8);
		chk("status after boot", {24'h0, !mute_on, 1'b0, mute_on, 5'h1c}, st);
		// A boot that never reaches ready has used up its bound: report at once
		if (st[4] !== 1'b1) finish_test();
		chk("model mode regs", 32'ha50f0c5a, {mr1, mr2, mr3, mr10});
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] r;
		logic e;
		int n;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk("cke at reset", 0, cke_q);
		rd_chk("status at reset", 8'h14, 32'h0);
		rd_chk("control at reset", 8'h00, 32'h0);
		apb(1'b1, 8'h40, 32'h1, r, e);
		chk("unmapped write error", 1, e);
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk("unmapped read", 32'h1, {r[30:0], e});
		wr(8'h04, 32'ha5);
		wr(8'h08, 32'hff);
		wr(8'h0c, 32'h3c);
		wr(8'h10, 32'h5a);
		rd_chk("mode 2 image", 8'h08, 32'h0f);
		rd_chk("mode 3 image", 8'h0c, 32'h0c);
		wr(8'h14, 32'hff);
		rd_chk("status read only", 8'h14, 32'h0);
		wr(8'h00, 32'h1);
		expect_boot(1'b0, cyc, 1'b0);
		// Restart from ready with precharge, device silent on polls
		// The restart picks the stored precharge bit, so it must stand one write earlier
		mute <= 1'b1;
		wr(8'h00, 32'h2);
		wr(8'h00, 32'ha);
		expect_boot(1'b1, cyc, 1'b1);
		rd_chk("control readback", 8'h00, 32'h2);
		// Power off drops clock enable and returns to the off state
		wr(8'h00, 32'h4);
		n = 0;
		while (cke_q !== 1'b0 && n < 4) begin
			@(posedge pclk);
			n++;
		end
		chk("cke at power off", 0, cke_q);
		if (cke_q !== 1'b0) finish_test();
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("state at power off", 32'h0, r & 32'h1f);
		// A restart is refused while off: no command, clock enable stays low
		wr(8'h00, 32'h8);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk("reinit while off", 32'h0, r & 32'h1f);
		chk("cke after refused reinit", 0, cke_q);
		mute <= 1'b0;
		wr(8'h00, 32'h1);
		expect_boot(1'b0, cyc, 1'b0);
		finish_test();
	end
endmodule // sis_ctrl_test
